/* src/add_carry_extended_exec.sv */
// execute logic for the two extended-add operations with carry, overflow and condition update
// assumes the register file answers the source read in the same cycle and a classic wishbone master
//------------------------------------------------------------
// Summary of operation
//------------------------------------------------------------
// Summary of operation
// [RULE1] minus-one form: source plus carry plus all-ones
// [RULE2] zero form: source plus carry plus zero
// [RULE3] decode primary 31, extended 234, fields
// [RULE4] decode extended 202, overflow-enable and record bits
// [RULE5] carry flag always updated from carry out
// [RULE6] overflow-enable updates overflow and summary overflow
// [RULE7] record flag updates condition field zero
// [RULE8] signed overflow; summary sticky, cleared by write
`timescale 1ns/1ps

module add_carry_extended_exec
    import addx_pkg::*;
(
    input wire logic clk_i, // core clock
    input wire logic rst_i, // synchronous reset, high
    input wire logic insn_valid_i, // instruction word offered
    input wire logic [INSN_W-1:0] insn_i, // instruction word
    output logic insn_taken_o, // word decoded as one of ours
    output logic [4:0] src_idx_o, // register file read index
    input wire logic [31:0] src_data_i, // register file read data
    output writeback_t wb_o, // registered write-back
    output logic carry_flag_o, // carry flag
    output logic overflow_flag_o, // overflow flag
    output logic summary_overflow_o, // sticky summary overflow
    output logic [3:0] cond0_o, // condition field 0: lt gt eq so
    input wire logic cyc_i, // wishbone cycle
    input wire logic stb_i, // wishbone strobe
    input wire logic we_i, // wishbone write
    input wire logic [3:0] adr_i, // wishbone byte address
    input wire logic [3:0] sel_i, // wishbone byte selects
    input wire logic [31:0] dat_i, // wishbone write data
    output logic [31:0] dat_o, // wishbone read data
    output logic ack_o, // wishbone acknowledge
    output logic irq_o // level interrupt
);

    //------------------------------------------------------------
    // decode
    //------------------------------------------------------------
    insn_t insn;
    wire logic primary_match;
    wire logic is_minus_one;
    wire logic is_zero;
    wire logic exec;
    assign insn = insn_t'(insn_i);
    assign primary_match = insn.primary == PRIMARY_OP; // RULE3 RULE4
    assign is_minus_one = primary_match && insn.ext_op == XO_ADD_MINUS_ONE; // RULE3
    assign is_zero = primary_match && insn.ext_op == XO_ADD_ZERO; // RULE4
    // the unused field is not checked: a word with junk there still executes
    assign exec = insn_valid_i && (is_minus_one || is_zero);
    assign insn_taken_o = exec;
    assign src_idx_o = insn.source_reg_field; // RULE3

    //------------------------------------------------------------
    // adder
    //------------------------------------------------------------
    logic [2:0] flags_reg;
    logic [2:0] flags_next;
    logic [3:0] cond_reg;
    logic [3:0] cond_next;
    wire logic carry_in;
    wire logic [31:0] addend;
    wire logic [32:0] src_ext;
    wire logic [32:0] addend_ext;
    wire logic [32:0] carry_ext;
    wire logic [32:0] sum;
    wire logic [31:0] result;
    wire logic carry_out;
    wire logic ovf;
    wire logic summary_after;
    wire logic res_neg;
    wire logic res_zero;
    wire logic res_pos;
    // the stored carry is used, so back-to-back adds chain through the flag
    assign carry_in = flags_reg[FLAG_CARRY];
    assign addend = is_minus_one ? ADDEND_MINUS_ONE : ADDEND_ZERO; // RULE1 RULE2
    // one spare bit on top catches the carry out
    assign src_ext = {1'b0, src_data_i};
    assign addend_ext = {1'b0, addend};
    assign carry_ext = {32'h0, carry_in};
    assign sum = src_ext + addend_ext + carry_ext; // RULE1 RULE2
    assign result = sum[31:0];
    assign carry_out = sum[32]; // RULE5
    // signed overflow: same-sign operands giving a result of the other sign
    assign ovf = (src_data_i[31] == addend[31]) && (result[31] != src_data_i[31]); // RULE8
    // sticky: only a bus write brings the summary bit back down
    assign summary_after = insn.overflow_enable ? (flags_reg[FLAG_SUMMARY] | ovf)
                                                 : flags_reg[FLAG_SUMMARY]; // RULE8
    assign res_neg = result[31]; // RULE7
    assign res_zero = result == 32'h0; // RULE7
    assign res_pos = !res_neg && !res_zero; // RULE7

    //------------------------------------------------------------
    // bus decode
    //------------------------------------------------------------
    logic ack_reg;
    logic [31:0] rdat_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_mask_reg;
    wire logic access;
    wire logic wr_lane;
    wire logic hit_flags;
    wire logic hit_cond;
    wire logic hit_status;
    wire logic hit_mask;
    wire logic wr_flags;
    wire logic wr_cond;
    wire logic wr_mask;
    wire logic rd_status;
    wire logic [31:0] rdat_next;
    wire logic [31:0] rdat_sel;
    // the access is done once, on the edge that raises ack
    assign access = cyc_i && stb_i && !ack_reg;
    // only the low byte carries bits, so a write without lane 0 is dropped
    assign wr_lane = access && we_i && sel_i[0];
    assign hit_flags = adr_i == ADDR_FLAGS;
    assign hit_cond = adr_i == ADDR_COND;
    assign hit_status = adr_i == ADDR_IRQ_STATUS;
    assign hit_mask = adr_i == ADDR_IRQ_MASK;
    assign wr_flags = wr_lane && hit_flags;
    assign wr_cond = wr_lane && hit_cond;
    assign wr_mask = wr_lane && hit_mask;
    assign rd_status = access && !we_i && hit_status;
    assign rdat_next = hit_flags ? {29'h0, flags_reg} :
                       hit_cond ? {28'h0, cond_reg} :
                       hit_status ? {30'h0, irq_status_reg} :
                       hit_mask ? {30'h0, irq_mask_reg} : 32'h0;
    // read data is zero outside ack so a stale word never leaks
    assign rdat_sel = access ? rdat_next : 32'h0;

    //------------------------------------------------------------
    // flag and condition update; an executing instruction wins over a bus write
    //------------------------------------------------------------
    always_comb begin
        flags_next = flags_reg;
        cond_next = cond_reg;
        if (wr_flags) begin
            flags_next = dat_i[2:0]; // RULE8
        end
        if (wr_cond) begin
            cond_next = dat_i[3:0];
        end
        if (exec) begin
            flags_next[FLAG_CARRY] = carry_out; // RULE5
            if (insn.overflow_enable) begin
                flags_next[FLAG_OVERFLOW] = ovf; // RULE6
                flags_next[FLAG_SUMMARY] = summary_after; // RULE6 RULE8
            end
            if (insn.record_flag) begin
                cond_next[COND_LT] = res_neg; // RULE7
                cond_next[COND_GT] = res_pos; // RULE7
                cond_next[COND_EQ] = res_zero; // RULE7
                cond_next[COND_SUMMARY] = summary_after; // RULE7
            end
        end
    end

    //------------------------------------------------------------
    // interrupts
    //------------------------------------------------------------
    wire logic [IRQ_W-1:0] irq_events;
    wire logic [IRQ_W-1:0] irq_status_next;
    wire logic [IRQ_W-1:0] irq_mask_next;
    wire logic [IRQ_W-1:0] irq_pending;
    assign irq_events[IRQ_EXEC] = exec;
    assign irq_events[IRQ_OVERFLOW] = exec && insn.overflow_enable && ovf;
    assign irq_pending = irq_status_reg & irq_mask_reg;

    // one sticky bit per event; a read clears it, but an event in the same cycle survives
    for (genvar b = 0; b < IRQ_W; b++) begin : g_irq
        assign irq_status_next[b] = (rd_status ? 1'b0 : irq_status_reg[b]) | irq_events[b];
        assign irq_mask_next[b] = wr_mask ? dat_i[b] : irq_mask_reg[b];
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            irq_status_reg <= IRQ_RESET;
            irq_mask_reg <= IRQ_RESET;
        end else begin
            irq_status_reg <= irq_status_next;
            irq_mask_reg <= irq_mask_next;
        end
    end

    //------------------------------------------------------------
    // registers
    //------------------------------------------------------------
    writeback_t wb_next;
    assign wb_next = '{en: exec, idx: insn.target_reg_field, data: result}; // RULE1 RULE2 RULE3

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            flags_reg <= FLAGS_RESET;
            cond_reg <= COND_RESET;
        end else begin
            flags_reg <= flags_next;
            cond_reg <= cond_next;
        end
    end

    // write-back is registered so the register file sees a clean one-cycle strobe
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_o <= '0;
        end else begin
            wb_o <= wb_next;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
            rdat_reg <= 32'h0;
        end else begin
            ack_reg <= access;
            rdat_reg <= rdat_sel;
        end
    end

    //------------------------------------------------------------
    // outputs
    //------------------------------------------------------------
    assign ack_o = ack_reg;
    assign dat_o = rdat_reg;
    assign irq_o = |irq_pending;
    assign carry_flag_o = flags_reg[FLAG_CARRY];
    assign overflow_flag_o = flags_reg[FLAG_OVERFLOW];
    assign summary_overflow_o = flags_reg[FLAG_SUMMARY];
    assign cond0_o = cond_reg;

endmodule // add_carry_extended_exec

/* shared/addx_pkg.sv */
// constants and types for the extended-add execute block
// assumes little-endian bit numbering in instruction fields (bit 0 is the lsb)
package addx_pkg;

    // ------------------------------------------------------------
    // instruction fields
    // ------------------------------------------------------------
    localparam int INSN_W = 32;
    localparam logic [5:0] PRIMARY_OP = 6'h1F;
    localparam logic [8:0] XO_ADD_MINUS_ONE = 9'h0EA;
    localparam logic [8:0] XO_ADD_ZERO = 9'h0CA;
    localparam logic [31:0] ADDEND_MINUS_ONE = 32'hFFFFFFFF;
    localparam logic [31:0] ADDEND_ZERO = 32'h00000000;

    // ------------------------------------------------------------
    // register map (byte addresses)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_FLAGS = 4'h0;
    localparam logic [3:0] ADDR_COND = 4'h4;
    localparam logic [3:0] ADDR_IRQ_STATUS = 4'h8;
    localparam logic [3:0] ADDR_IRQ_MASK = 4'hC;

    // flags register bit positions
    localparam int FLAG_CARRY = 0;
    localparam int FLAG_OVERFLOW = 1;
    localparam int FLAG_SUMMARY = 2;
    localparam logic [2:0] FLAGS_RESET = 3'h0;

    // condition field bit positions
    localparam int COND_SUMMARY = 0;
    localparam int COND_EQ = 1;
    localparam int COND_GT = 2;
    localparam int COND_LT = 3;
    localparam logic [3:0] COND_RESET = 4'h0;

    // interrupt event bits
    localparam int IRQ_EXEC = 0;
    localparam int IRQ_OVERFLOW = 1;
    localparam int IRQ_W = 2;
    localparam logic [1:0] IRQ_RESET = 2'h0;

    // decoded instruction
    typedef struct packed {
        logic [5:0] primary;
        logic [4:0] target_reg_field;
        logic [4:0] source_reg_field;
        logic [4:0] unused;
        logic overflow_enable;
        logic [8:0] ext_op;
        logic record_flag;
    } insn_t;

    // register-file write-back
    typedef struct packed {
        logic en;
        logic [4:0] idx;
        logic [31:0] data;
    } writeback_t;

endpackage

/* verification/add_carry_extended_exec_chk.sv */
// checker for the extended-add execute block
// assumes it is bound to the block's ports
`timescale 1ns/1ps
module add_carry_extended_exec_chk
    import addx_pkg::*;
(
    input wire logic clk_i, rst_i, insn_valid_i, insn_taken_o, cyc_i, stb_i, we_i, ack_o,
    input wire logic [31:0] insn_i, src_data_i,
    input wire writeback_t wb_o,
    input wire logic carry_flag_o, overflow_flag_o, summary_overflow_o,
    input wire logic [3:0] cond0_o
);
    wire logic [31:0] add_w = (insn_i[9:1] == XO_ADD_MINUS_ONE) ? ADDEND_MINUS_ONE : ADDEND_ZERO;
    wire logic [32:0] sum_w = {1'b0, src_data_i} + {1'b0, add_w} + {32'h0, carry_flag_o};
    wire logic ovf_w = (src_data_i[31] == add_w[31]) && (sum_w[31] != src_data_i[31]);
    wire logic [2:0] res_w = {sum_w[31], !sum_w[31] && sum_w[31:0] != 32'h0, sum_w[31:0] == 32'h0};
    // a bus write may legally change flags in the same cycle
    wire logic bw_w = cyc_i && stb_i && we_i;
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence ack_pulse_s;
        ack_o ##1 !ack_o;
    endsequence
    AST_DECODE: assert property (insn_taken_o == (insn_valid_i && insn_i[31:26] == PRIMARY_OP
        && (insn_i[9:1] == XO_ADD_MINUS_ONE || insn_i[9:1] == XO_ADD_ZERO))) else $error("decode");
    AST_RESULT: assert property (insn_taken_o |=> wb_o.en && wb_o.idx == $past(insn_i[25:21])
        && wb_o.data == $past(sum_w[31:0])) else $error("result");
    AST_WB_CAUSE: assert property (wb_o.en |-> $past(insn_taken_o)) else $error("stray writeback");
    AST_CARRY: assert property (insn_taken_o |=> carry_flag_o == $past(sum_w[32])) else $error("carry");
    AST_OV_SET: assert property (insn_taken_o && insn_i[10] |=> overflow_flag_o == $past(ovf_w))
        else $error("overflow");
    AST_SO_STICKY: assert property (insn_taken_o && insn_i[10] && (ovf_w || summary_overflow_o)
        |=> summary_overflow_o) else $error("summary");
    AST_FLAG_HOLD: assert property (insn_taken_o && !insn_i[10] && !bw_w
        |=> $stable({overflow_flag_o, summary_overflow_o})) else $error("flags moved");
    AST_COND_HOLD: assert property (insn_taken_o && !insn_i[0] && !bw_w |=> $stable(cond0_o))
        else $error("cond moved");
    AST_COND_SET: assert property (insn_taken_o && insn_i[0]
        |=> cond0_o == {$past(res_w), summary_overflow_o}) else $error("cond");
    AST_ACK: assert property (cyc_i && stb_i && !ack_o |=> ack_pulse_s) else $error("ack");
endmodule // add_carry_extended_exec_chk
bind add_carry_extended_exec add_carry_extended_exec_chk u_chk (.*);

/* verification/addx_rf.sv */
// register file seen from issue: combinational read, write-back at the edge
// assumes at most one write-back per cycle
`timescale 1ns/1ps
module addx_rf
    import addx_pkg::*;
(
    input wire logic clk_i, // core clock
    input wire logic [4:0] src_idx_i, // read index
    input wire writeback_t wb_i, // write-back
    output logic [31:0] src_data_o // read data
);
    logic [31:0] regs [32];
    initial foreach (regs[i]) regs[i] = 32'h0;
    assign src_data_o = regs[src_idx_i];
    always @(posedge clk_i) begin
        if (wb_i.en) begin
            regs[wb_i.idx] <= wb_i.data;
        end
    end
endmodule // addx_rf

/* verification/add_carry_extended_exec_bench.sv */
// self-checking bench for the extended-add execute block
// assumes the register-file model and a wishbone master on the bench
`timescale 1ns/1ps
module add_carry_extended_exec_bench;
    import addx_pkg::*;
    logic clk_i = 0, rst_i = 1, insn_valid_i = 0, cyc_i = 0, stb_i = 0, we_i = 0;
    logic [31:0] insn_i = 32'h0, dat_i = 32'h0, src_data_i, dat_o;
    logic [3:0] adr_i = 4'h0, sel_i = 4'h0, cond0_o;
    logic [4:0] src_idx_o;
    logic insn_taken_o, carry_flag_o, overflow_flag_o, summary_overflow_o, ack_o, irq_o;
    writeback_t wb_o;
    int num_errors = 0, n_tests = 0;
    always #5 clk_i = ~clk_i;
    add_carry_extended_exec u_add_carry_extended_exec (.*);
    addx_rf u_addx_rf (.clk_i, .src_idx_i(src_idx_o), .wb_i(wb_o), .src_data_o(src_data_i));
    task finish_test;
        $display("errors %0d checks %0d", num_errors, n_tests);
        if (num_errors == 0 && n_tests > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    task chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            num_errors++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // classic cycle: hold until ack sampled, then drop for one cycle
    task wb(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
        int n;
        n = 0;
        {cyc_i, stb_i, we_i, adr_i, dat_i, sel_i} <= {2'b11, w, a, d, 4'hF};
        do begin
            @(posedge clk_i);
            n++;
        end while (ack_o !== 1'b1 && n < 50);
        if (ack_o !== 1'b1) begin
            num_errors++;
            finish_test;
        end
        q = dat_o;
        {cyc_i, stb_i} <= 2'b00;
        @(posedge clk_i);
    endtask
    task rd(input logic [3:0] a, input logic [31:0] e);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(q, e);
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask
    function automatic insn_t mk(input logic [4:0] t, s, input logic oe, input logic [8:0] xo, input logic rc);
        return '{PRIMARY_OP, t, s, 5'h0, oe, xo, rc};
    endfunction
    task issue(input insn_t w, input logic tk);
        insn_i <= w;
        insn_valid_i <= 1'b1;
        #1 chk(32'(insn_taken_o), 32'(tk));
        @(posedge clk_i);
        insn_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task t_reset;
        rd(ADDR_FLAGS, 32'h0);
        rd(ADDR_COND, 32'h0);
        rd(ADDR_IRQ_STATUS, 32'h0);
        rd(4'h2, 32'h0);
        wr(ADDR_IRQ_MASK, 32'h2);
        rd(ADDR_IRQ_MASK, 32'h2);
    endtask
    // all eight forms; each source chosen to overflow
    task t_variants;
        logic oe, rc, z;
        for (int i = 0; i < 8; i++) begin
            {z, rc, oe} = i[2:0];
            wr(ADDR_FLAGS, {31'h0, z});
            wr(ADDR_COND, 32'h6);
            u_addx_rf.regs[4] = z ? 32'h7FFFFFFF : 32'h80000000;
            issue(mk(5'h6, 5'h4, oe, z ? XO_ADD_ZERO : XO_ADD_MINUS_ONE, rc), 1'b1);
            chk(u_addx_rf.regs[6], z ? 32'h80000000 : 32'h7FFFFFFF);
            chk(32'(irq_o), 32'(oe));
            rd(ADDR_FLAGS, {29'h0, oe, oe, !z});
            rd(ADDR_COND, rc ? {28'h0, z, !z, 1'b0, oe} : 32'h6);
            rd(ADDR_IRQ_STATUS, {30'h0, oe, 1'b1});
            rd(ADDR_IRQ_STATUS, 32'h0);
        end
    endtask
    task t_chain;
        u_addx_rf.regs[4] = 32'hFFFFFFFF;
        wr(ADDR_FLAGS, 32'h1);
        insn_i <= mk(5'h6, 5'h4, 1'b0, XO_ADD_ZERO, 1'b0);
        insn_valid_i <= 1'b1;
        @(posedge clk_i);
        insn_i <= mk(5'h7, 5'h5, 1'b0, XO_ADD_ZERO, 1'b0);
        @(posedge clk_i);
        insn_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
        chk(u_addx_rf.regs[6], 32'h0);
        chk(u_addx_rf.regs[7], 32'h1);
        rd(ADDR_FLAGS, 32'h0);
        u_addx_rf.regs[6] = 32'h5A;
        issue(mk(5'h6, 5'h4, 1'b1, 9'h01C, 1'b1), 1'b0);
        chk(u_addx_rf.regs[6], 32'h5A);
    endtask
    // clean adds with overflow enabled: overflow drops, summary stays until written
    task t_sticky;
        u_addx_rf.regs[8] = 32'h0;
        u_addx_rf.regs[9] = 32'h5A;
        wr(ADDR_FLAGS, 32'h6);
        issue(mk(5'h9, 5'h8, 1'b1, XO_ADD_ZERO, 1'b1), 1'b1);
        chk(u_addx_rf.regs[9], 32'h0);
        rd(ADDR_FLAGS, 32'h4);
        rd(ADDR_COND, 32'h3);
        issue(mk(5'h9, 5'h8, 1'b1, XO_ADD_MINUS_ONE, 1'b1), 1'b1);
        chk(u_addx_rf.regs[9], 32'hFFFFFFFF);
        chk(32'(irq_o), 32'h0);
        rd(ADDR_FLAGS, 32'h4);
        rd(ADDR_COND, 32'h9);
        rd(ADDR_IRQ_STATUS, 32'h1);
        wr(ADDR_FLAGS, 32'h0);
        rd(ADDR_FLAGS, 32'h0);
    endtask
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset;
        t_variants;
        t_chain;
        t_sticky;
        finish_test;
    end
endmodule // add_carry_extended_exec_bench
